// ### common/irsir_pkg.sv
// Summary of operation
// - Reset input clears all configuration state
// - Reset loads 9600 bit/s and fixed pulse
// - Shutdown output is inverted reset input
// - Oscillator stopped while reset input high
// - Data mode shortens transmit bits to pulses
// - Data mode stretches received pulses to bit
// - Program mode takes characters as control word
// - New setting applies when select returns low, or at once on a bus write in data mode
// - All timing derived from 3.6864 MHz reference
// - Pulse width fixed 1.627 us or 3/16
// - Thirteen rates from 1200 to 115200
// - Stretched receive output is active high
// - Optical transmit output is active high
// - Two active-low user programmable output bits
// - Active-low transmit and receive activity indicators
package irsir_pkg;

  // Reference clock and rate table
  localparam longint REF_CLK_HZ = 64'd3686400;
  localparam int     NUM_RATES  = 13;
  localparam int     RATE_W     = 4;
  localparam int     PERIOD_W   = 12;
  localparam int unsigned RATE_HZ [NUM_RATES] = '{
    1200, 1800, 2400, 3600, 4800, 7200, 9600,
    14400, 19200, 28800, 38400, 57600, 115200
  };

  // Fixed pulse: time in ps, ticks rounded up
  localparam longint FIXED_PULSE_PS    = 64'd1627000;
  localparam longint PS_PER_S          = 64'd1000000000000;
  localparam logic [PERIOD_W-1:0] FIXED_PULSE_TICKS =
    PERIOD_W'((FIXED_PULSE_PS * REF_CLK_HZ + PS_PER_S - 64'd1) / PS_PER_S);

  // Avalon register offsets (byte addresses)
  localparam int             ADDR_W     = 4;
  localparam logic [ADDR_W-1:0] OFS_CONFIG = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 4'h4;

  // Control word and config register fields
  localparam int CW_RATE_LSB  = 0;
  localparam int CW_WIDTH_BIT = 4;
  localparam int CW_FRONT_BIT = 5;
  localparam int CW_BACK_BIT  = 6;

  // Status register fields beyond the config copy
  localparam int ST_SELECT_BIT = 8;
  localparam int ST_RESET_BIT  = 9;
  localparam int ST_TXACT_BIT  = 10;
  localparam int ST_RXACT_BIT  = 11;
  localparam int ST_OSC_BIT    = 12;

  // Reset values
  localparam logic [RATE_W-1:0] RATE_DEFAULT  = 4'h6;
  localparam logic              WIDTH_DEFAULT = 1'h0;
  localparam logic              USER_DEFAULT  = 1'h0;

  // Control word receiver states
  typedef enum logic [3:0] {
    RX_IDLE  = 4'h1,
    RX_START = 4'h2,
    RX_DATA  = 4'h4,
    RX_STOP  = 4'h8
  } irsir_rx_state_t;

  // Bit period in reference ticks for a rate index
  function automatic logic [PERIOD_W-1:0] rate_period(input logic [RATE_W-1:0] idx);
    logic [PERIOD_W-1:0] p;
    p = PERIOD_W'(REF_CLK_HZ / 64'(RATE_HZ[RATE_DEFAULT]));
    for (int i = 0; i < NUM_RATES; i++) begin
      if (idx == RATE_W'(i)) begin
        p = PERIOD_W'(REF_CLK_HZ / 64'(RATE_HZ[i]));
      end
    end
    return p;
  endfunction

endpackage

// ### rtl/irsir_tick_gen.sv
`timescale 1ns/1ps
// Turns the sampled reference clock into one-cycle ticks
module irsir_tick_gen (
  // Clock and control
  input  wire logic clk,
  input  wire logic reset,
  input  wire logic ce,
  // Oscillator run and reference input
  input  wire logic run,
  input  wire logic ref_in,
  // Tick out
  output logic      tick
);

  logic s1, s2, s3;                  // Synchroniser and edge history
  logic next_s1, next_s2, next_s3;
  logic next_tick;

  // Next values: edge seen only past the second stage
  always_comb begin
    next_s1   = ref_in;
    next_s2   = s1;
    next_s3   = s2;
    next_tick = run & s2 & ~s3;
  end

  // Registers
  always_ff @(posedge clk) begin
    if (reset) begin
      s1   <= 1'h0;
      s2   <= 1'h0;
      s3   <= 1'h0;
      tick <= 1'h0;
    end else if (ce) begin
      s1   <= next_s1;
      s2   <= next_s2;
      s3   <= next_s3;
      tick <= next_tick;
    end
  end

endmodule // irsir_tick_gen

// ### rtl/irsir_word_rx.sv
`timescale 1ns/1ps
// Receives one control character from the serial side line
module irsir_word_rx (
  // Clock and control
  input  wire logic                           clk,
  input  wire logic                           reset,
  input  wire logic                           ce,
  input  wire logic                           enable,
  input  wire logic                           tick,
  // Line, high means space
  input  wire logic                           line_space,
  input  wire logic [irsir_pkg::PERIOD_W-1:0] period,
  // Received character
  output logic      [7:0]                     data,
  output logic                                valid
);

  irsir_pkg::irsir_rx_state_t state, next_state;
  logic [irsir_pkg::PERIOD_W-1:0] cnt, next_cnt;    // Ticks in current bit
  logic [3:0]                     nbit, next_nbit;  // Data bits taken
  logic [7:0]                     next_data;
  logic                           next_valid;

  // Next state: start checked mid-bit, then one sample per period
  always_comb begin
    next_state = state;
    next_cnt   = cnt;
    next_nbit  = nbit;
    next_data  = data;
    next_valid = 1'h0;
    if (!enable) begin
      next_state = irsir_pkg::RX_IDLE;
      next_cnt   = '0;
    end else begin
      case (state)
        irsir_pkg::RX_IDLE: begin
          next_cnt = '0;
          if (line_space) begin
            next_state = irsir_pkg::RX_START;
          end
        end
        irsir_pkg::RX_START: begin
          if (tick) begin
            next_cnt = cnt + 1'b1;
            if (cnt == (period >> 1)) begin
              next_cnt   = '0;
              next_nbit  = '0;
              next_state = line_space ? irsir_pkg::RX_DATA : irsir_pkg::RX_IDLE;
            end
          end
        end
        irsir_pkg::RX_DATA: begin
          if (tick) begin
            next_cnt = cnt + 1'b1;
            if (cnt == period - 1'b1) begin
              next_cnt  = '0;
              next_data = {~line_space, data[7:1]};   // LSB first
              next_nbit = nbit + 1'b1;
              if (nbit == 4'h7) begin
                next_state = irsir_pkg::RX_STOP;
              end
            end
          end
        end
        irsir_pkg::RX_STOP: begin
          if (tick) begin
            next_cnt = cnt + 1'b1;
            if (cnt == period - 1'b1) begin
              next_valid = ~line_space;                // Framing error drops it
              next_state = irsir_pkg::RX_IDLE;
            end
          end
        end
        default: begin
          next_state = irsir_pkg::RX_IDLE;
        end
      endcase
    end
  end

  // Registers
  always_ff @(posedge clk) begin
    if (reset) begin
      state <= irsir_pkg::RX_IDLE;
      cnt   <= '0;
      nbit  <= '0;
      data  <= 8'h00;
      valid <= 1'h0;
    end else if (ce) begin
      state <= next_state;
      cnt   <= next_cnt;
      nbit  <= next_nbit;
      data  <= next_data;
      valid <= next_valid;
    end
  end

endmodule // irsir_word_rx

// ### rtl/irsir_endec.sv
`timescale 1ns/1ps
// Infrared pulse encoder and decoder with Avalon register access
module irsir_endec (
  // Clock, reset, enable
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        ce,
  // Avalon-MM slave
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // Reference clock and control pins
  input  wire logic        ref_clock_in,
  input  wire logic        ir_reset_in,
  input  wire logic        program_or_data_select,
  output logic             osc_enable_out,
  output logic             transceiver_shutdown_out,
  // Serial side
  input  wire logic        serial_side_tx_in,
  output logic             serial_side_rx_out,
  // Optical side
  output logic             optical_tx_out,
  input  wire logic        optical_rx_in,
  // User bits and indicators, active low
  output logic             user_out_front_n,
  output logic             user_out_back_n,
  output logic             tx_activity_indicator_n,
  output logic             rx_activity_indicator_n
);

  localparam int RW = irsir_pkg::RATE_W;
  localparam int PW = irsir_pkg::PERIOD_W;

  logic          tick;                       // Reference tick
  logic [7:0]    cw_data;                    // Received control word
  logic          cw_valid;
  logic          data_mode;                  // Select low, not in reset
  logic [PW-1:0] period;                     // Bit period in ticks
  logic [PW-1:0] width;                      // Pulse width in ticks
  logic [PW+1:0] period_x3;

  // Reference tick, stopped while the reset pin is high
  irsir_tick_gen u_tick (
    .clk    (clk),
    .reset  (reset),
    .ce     (ce),
    .run    (~ir_reset_in),
    .ref_in (ref_clock_in),
    .tick   (tick)
  );

  // Control word receiver, active only in programming mode
  irsir_word_rx u_word (
    .clk        (clk),
    .reset      (reset),
    .ce         (ce),
    .enable     (program_or_data_select & ~ir_reset_in),
    .tick       (tick),
    .line_space (serial_side_tx_in),
    .period     (period),
    .data       (cw_data),
    .valid      (cw_valid)
  );

  // ---------------- Pin sampling ----------------
  logic sel_q, next_sel_q;                   // Select history
  logic rx_s1, rx_s2, rx_s3;                 // Optical input sync
  logic next_rx_s1, next_rx_s2, next_rx_s3;
  logic tx_prev, next_tx_prev;               // Serial tx history

  // Next pin history
  always_comb begin
    next_sel_q  = program_or_data_select;
    next_rx_s1  = optical_rx_in;
    next_rx_s2  = rx_s1;
    next_rx_s3  = rx_s2;
    next_tx_prev = serial_side_tx_in;
  end

  // Pin history registers
  always_ff @(posedge clk) begin
    if (reset) begin
      sel_q   <= 1'h0;
      rx_s1   <= 1'h1;
      rx_s2   <= 1'h1;
      rx_s3   <= 1'h1;
      tx_prev <= 1'h0;
    end else if (ce) begin
      sel_q   <= next_sel_q;
      rx_s1   <= next_rx_s1;
      rx_s2   <= next_rx_s2;
      rx_s3   <= next_rx_s3;
      tx_prev <= next_tx_prev;
    end
  end

  // ---------------- Configuration ----------------
  logic [RW-1:0] act_rate, pend_rate, next_act_rate, next_pend_rate;
  logic          act_width, pend_width, next_act_width, next_pend_width;
  logic          act_front, pend_front, next_act_front, next_pend_front;
  logic          act_back, pend_back, next_act_back, next_pend_back;
  logic          bus_take;                   // Request accepted this edge
  logic          cfg_wr;                     // Config register write

  assign data_mode = ~program_or_data_select & ~ir_reset_in;
  assign period    = irsir_pkg::rate_period(act_rate);
  assign period_x3 = {2'b00, period} + {1'b0, period, 1'b0};
  assign width     = act_width ? {2'b00, period_x3[PW+1:4]}
                               : irsir_pkg::FIXED_PULSE_TICKS;
  assign bus_take  = (avs_read | avs_write) & ~avs_waitrequest;
  assign cfg_wr    = bus_take & avs_write & (avs_address == irsir_pkg::OFS_CONFIG);

  // Next config: pending from word or bus, active on select fall or on a data-mode bus write
  always_comb begin
    next_act_rate   = act_rate;
    next_act_width  = act_width;
    next_act_front  = act_front;
    next_act_back   = act_back;
    next_pend_rate  = pend_rate;
    next_pend_width = pend_width;
    next_pend_front = pend_front;
    next_pend_back  = pend_back;
    if (ir_reset_in) begin
      // Defaults while the reset pin is high
      next_act_rate   = irsir_pkg::RATE_DEFAULT;
      next_act_width  = irsir_pkg::WIDTH_DEFAULT;
      next_act_front  = irsir_pkg::USER_DEFAULT;
      next_act_back   = irsir_pkg::USER_DEFAULT;
      next_pend_rate  = irsir_pkg::RATE_DEFAULT;
      next_pend_width = irsir_pkg::WIDTH_DEFAULT;
      next_pend_front = irsir_pkg::USER_DEFAULT;
      next_pend_back  = irsir_pkg::USER_DEFAULT;
    end else begin
      // Control word: out-of-range rate drops the word
      if (cw_valid && cw_data[irsir_pkg::CW_RATE_LSB +: RW] < RW'(irsir_pkg::NUM_RATES)) begin
        next_pend_rate  = cw_data[irsir_pkg::CW_RATE_LSB +: RW];
        next_pend_width = cw_data[irsir_pkg::CW_WIDTH_BIT];
        next_pend_front = cw_data[irsir_pkg::CW_FRONT_BIT];
        next_pend_back  = cw_data[irsir_pkg::CW_BACK_BIT];
      end
      // Bus write of config, same layout
      if (cfg_wr && avs_writedata[irsir_pkg::CW_RATE_LSB +: RW] < RW'(irsir_pkg::NUM_RATES)) begin
        next_pend_rate  = avs_writedata[irsir_pkg::CW_RATE_LSB +: RW];
        next_pend_width = avs_writedata[irsir_pkg::CW_WIDTH_BIT];
        next_pend_front = avs_writedata[irsir_pkg::CW_FRONT_BIT];
        next_pend_back  = avs_writedata[irsir_pkg::CW_BACK_BIT];
      end
      // Commit when select goes low, or at once in data mode
      if ((sel_q && !program_or_data_select) || (cfg_wr && !program_or_data_select)) begin
        next_act_rate  = next_pend_rate;
        next_act_width = next_pend_width;
        next_act_front = next_pend_front;
        next_act_back  = next_pend_back;
      end
    end
  end

  // Config registers
  always_ff @(posedge clk) begin
    if (reset) begin
      act_rate   <= irsir_pkg::RATE_DEFAULT;
      act_width  <= irsir_pkg::WIDTH_DEFAULT;
      act_front  <= irsir_pkg::USER_DEFAULT;
      act_back   <= irsir_pkg::USER_DEFAULT;
      pend_rate  <= irsir_pkg::RATE_DEFAULT;
      pend_width <= irsir_pkg::WIDTH_DEFAULT;
      pend_front <= irsir_pkg::USER_DEFAULT;
      pend_back  <= irsir_pkg::USER_DEFAULT;
    end else if (ce) begin
      act_rate   <= next_act_rate;
      act_width  <= next_act_width;
      act_front  <= next_act_front;
      act_back   <= next_act_back;
      pend_rate  <= next_pend_rate;
      pend_width <= next_pend_width;
      pend_front <= next_pend_front;
      pend_back  <= next_pend_back;
    end
  end

  // ---------------- Transmit shortener ----------------
  logic [PW-1:0] slot_cnt, next_slot_cnt;    // Ticks into a space bit
  logic [PW-1:0] pulse_cnt, next_pulse_cnt;  // Ticks of pulse left
  logic          next_optical_tx;

  // Next shortener: pulse at each space bit start
  always_comb begin
    next_slot_cnt  = slot_cnt;
    next_pulse_cnt = pulse_cnt;
    if (!data_mode) begin
      next_slot_cnt  = '0;
      next_pulse_cnt = '0;
    end else begin
      if (pulse_cnt != '0 && tick) begin
        next_pulse_cnt = pulse_cnt - 1'b1;
      end
      if (!serial_side_tx_in) begin
        next_slot_cnt = '0;
      end else if (!tx_prev) begin
        next_slot_cnt  = '0;
        next_pulse_cnt = width;
      end else if (tick) begin
        next_slot_cnt = slot_cnt + 1'b1;
        if (slot_cnt == period - 1'b1) begin
          next_slot_cnt  = '0;               // Next space bit in a run
          next_pulse_cnt = width;
        end
      end
    end
    next_optical_tx = (next_pulse_cnt != '0);
  end

  // Shortener registers
  always_ff @(posedge clk) begin
    if (reset) begin
      slot_cnt       <= '0;
      pulse_cnt      <= '0;
      optical_tx_out <= 1'h0;
    end else if (ce) begin
      slot_cnt       <= next_slot_cnt;
      pulse_cnt      <= next_pulse_cnt;
      optical_tx_out <= next_optical_tx;
    end
  end

  // ---------------- Receive stretcher ----------------
  logic [PW-1:0] stretch_cnt, next_stretch_cnt;  // Ticks of bit left
  logic          next_rx_out;

  // Next stretcher: falling optical edge starts one bit
  always_comb begin
    next_stretch_cnt = stretch_cnt;
    if (!data_mode) begin
      next_stretch_cnt = '0;
    end else if (!rx_s2 && rx_s3) begin
      next_stretch_cnt = period;
    end else if (stretch_cnt != '0 && tick) begin
      next_stretch_cnt = stretch_cnt - 1'b1;
    end
    next_rx_out = (next_stretch_cnt != '0);
  end

  // Stretcher registers
  always_ff @(posedge clk) begin
    if (reset) begin
      stretch_cnt        <= '0;
      serial_side_rx_out <= 1'h0;
    end else if (ce) begin
      stretch_cnt        <= next_stretch_cnt;
      serial_side_rx_out <= next_rx_out;
    end
  end

  // ---------------- Pin outputs ----------------
  logic next_shutdown, next_osc, next_front_n, next_back_n, next_txind_n, next_rxind_n;

  // Next pin levels
  always_comb begin
    next_shutdown = ~ir_reset_in;
    next_osc      = ~ir_reset_in;
    next_front_n  = ~act_front;
    next_back_n   = ~act_back;
    next_txind_n  = ~(data_mode & serial_side_tx_in);
    next_rxind_n  = ~next_rx_out;
  end

  // Pin output registers
  always_ff @(posedge clk) begin
    if (reset) begin
      transceiver_shutdown_out <= 1'h1;
      osc_enable_out           <= 1'h1;
      user_out_front_n         <= 1'h1;
      user_out_back_n          <= 1'h1;
      tx_activity_indicator_n  <= 1'h1;
      rx_activity_indicator_n  <= 1'h1;
    end else if (ce) begin
      transceiver_shutdown_out <= next_shutdown;
      osc_enable_out           <= next_osc;
      user_out_front_n         <= next_front_n;
      user_out_back_n          <= next_back_n;
      tx_activity_indicator_n  <= next_txind_n;
      rx_activity_indicator_n  <= next_rxind_n;
    end
  end

  // ---------------- Avalon slave ----------------
  logic        next_waitreq;
  logic [31:0] next_rdata;

  // Next bus answer: one wait cycle, then data with waitrequest low
  always_comb begin
    next_waitreq = ~((avs_read | avs_write) & avs_waitrequest);
    next_rdata   = avs_readdata;
    if (avs_read && avs_waitrequest) begin
      next_rdata = 32'h0000_0000;            // Unmapped reads as zero
      if (avs_address == irsir_pkg::OFS_CONFIG) begin
        next_rdata[irsir_pkg::CW_RATE_LSB +: RW]  = pend_rate;
        next_rdata[irsir_pkg::CW_WIDTH_BIT]       = pend_width;
        next_rdata[irsir_pkg::CW_FRONT_BIT]       = pend_front;
        next_rdata[irsir_pkg::CW_BACK_BIT]        = pend_back;
      end else if (avs_address == irsir_pkg::OFS_STATUS) begin
        next_rdata[irsir_pkg::CW_RATE_LSB +: RW]  = act_rate;
        next_rdata[irsir_pkg::CW_WIDTH_BIT]       = act_width;
        next_rdata[irsir_pkg::CW_FRONT_BIT]       = act_front;
        next_rdata[irsir_pkg::CW_BACK_BIT]        = act_back;
        next_rdata[irsir_pkg::ST_SELECT_BIT]      = program_or_data_select;
        next_rdata[irsir_pkg::ST_RESET_BIT]       = ir_reset_in;
        next_rdata[irsir_pkg::ST_TXACT_BIT]       = optical_tx_out;
        next_rdata[irsir_pkg::ST_RXACT_BIT]       = serial_side_rx_out;
        next_rdata[irsir_pkg::ST_OSC_BIT]         = osc_enable_out;
      end
    end
  end

  // Bus registers
  always_ff @(posedge clk) begin
    if (reset) begin
      avs_waitrequest <= 1'h1;
      avs_readdata    <= 32'h0000_0000;
    end else if (ce) begin
      avs_waitrequest <= next_waitreq;
      avs_readdata    <= next_rdata;
    end
  end

endmodule // irsir_endec

// ### verification/irsir_endec_checker.sv
`timescale 1ns/1ps
// Pin-level timing and polarity checks for the endec
module irsir_endec_checker (
  // Clock and resets
  input  wire logic clk,
  input  wire logic reset,
  input  wire logic ir_reset_in,
  // Bus handshake
  input  wire logic avs_read,
  input  wire logic avs_write,
  input  wire logic avs_waitrequest,
  // Mode and link pins
  input  wire logic program_or_data_select,
  input  wire logic serial_side_tx_in,
  input  wire logic optical_rx_in,
  input  wire logic optical_tx_out,
  input  wire logic serial_side_rx_out,
  input  wire logic osc_enable_out,
  input  wire logic transceiver_shutdown_out,
  // Active-low outputs
  input  wire logic user_out_front_n,
  input  wire logic tx_activity_indicator_n,
  input  wire logic rx_activity_indicator_n
);
  // All checks on the system clock
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // Shutdown and oscillator follow the reset pin one edge late
  a_shutdown_inverse: assert property (!$past(reset) |-> transceiver_shutdown_out == !$past(ir_reset_in))
    else $error("shutdown not inverse of reset pin");
  a_osc_stopped: assert property (!$past(reset) |-> osc_enable_out == !$past(ir_reset_in))
    else $error("oscillator not stopped by reset pin");
  // Programming mode blocks both links
  a_program_no_tx: assert property (program_or_data_select [*2] |-> !optical_tx_out)
    else $error("optical pulse in programming mode");
  a_program_no_rx: assert property (program_or_data_select [*2] |-> !serial_side_rx_out)
    else $error("receive output in programming mode");
  // Rising serial line starts a high optical pulse next edge
  a_tx_pulse_start: assert property (!program_or_data_select && !ir_reset_in && $rose(serial_side_tx_in) |=> optical_tx_out)
    else $error("optical pulse did not start");
  a_tx_min_width: assert property ($rose(optical_tx_out) |-> (optical_tx_out || ir_reset_in || program_or_data_select) [*8])
    else $error("optical pulse too short");
  // Falling optical input stretches after synchronising
  a_rx_stretch: assert property (!program_or_data_select && !ir_reset_in && $fell(optical_rx_in) |-> ##[2:6] serial_side_rx_out)
    else $error("receive output did not rise");
  // Indicator lamps
  a_rx_lamp: assert property (serial_side_rx_out |-> ##[0:1] !rx_activity_indicator_n)
    else $error("receive lamp not lit");
  a_tx_lamp: assert property ((serial_side_tx_in && !program_or_data_select && !ir_reset_in) [*2] |-> !tx_activity_indicator_n)
    else $error("transmit lamp not lit");
  // Bus answers after exactly one wait cycle
  a_bus_one_wait: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("bus answer timing wrong");
  // Outputs idle right after reset
  a_user_reset: assert property ($fell(reset) |-> user_out_front_n && tx_activity_indicator_n && rx_activity_indicator_n)
    else $error("active-low outputs not idle after reset");
endmodule // irsir_endec_checker

bind irsir_endec irsir_endec_checker u_chk (
  .clk, .reset, .ir_reset_in, .avs_read, .avs_write, .avs_waitrequest,
  .program_or_data_select, .serial_side_tx_in, .optical_rx_in, .optical_tx_out,
  .serial_side_rx_out, .osc_enable_out, .transceiver_shutdown_out, .user_out_front_n,
  .tx_activity_indicator_n, .rx_activity_indicator_n
);

// ### verification/irsir_far_model.sv
`timescale 1ns/1ps
// External oscillator and optical receiver model
module irsir_far_model (
  // Bench request for one optical pulse
  input  wire logic fire,
  // Pins toward the endec
  output logic      ref_clock_in,
  output logic      optical_rx_in
);
  // Free-running nominal reference clock
  initial begin
    ref_clock_in = 1'b0;
    forever #135.634 ref_clock_in = ~ref_clock_in;
  end
  // Active-low pulse of 2 us, idle high
  initial begin
    optical_rx_in = 1'b1;
    forever begin
      @(posedge fire);
      optical_rx_in <= 1'b0;
      #2000;
      optical_rx_in <= 1'b1;
    end
  end
endmodule // irsir_far_model

// ### verification/tb.sv
`timescale 1ns/1ps
// Self-checking bench for the infrared endec
module tb;
  // Clock, reset and bus
  logic        clk, reset, avs_read, avs_write, avs_waitrequest;
  logic [3:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd;
  // Device pins
  logic        ref_clock_in, ir_reset_in, program_or_data_select, osc_enable_out;
  logic        transceiver_shutdown_out, serial_side_tx_in, serial_side_rx_out;
  logic        optical_tx_out, optical_rx_in, user_out_front_n, user_out_back_n;
  logic        tx_activity_indicator_n, rx_activity_indicator_n, fire;
  // Scoreboard
  int          n_mismatch, comparisons, w;

  // Device and far side
  irsir_endec u_dut (.clk, .reset, .ce(1'b1), .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_readdata, .avs_waitrequest, .ref_clock_in, .ir_reset_in,
    .program_or_data_select, .osc_enable_out, .transceiver_shutdown_out,
    .serial_side_tx_in, .serial_side_rx_out, .optical_tx_out, .optical_rx_in,
    .user_out_front_n, .user_out_back_n, .tx_activity_indicator_n, .rx_activity_indicator_n);
  irsir_far_model u_far (.fire, .ref_clock_in, .optical_rx_in);

  // 25 MHz clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // Word compare
  task automatic check_eq(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Cycle count inside a window
  task automatic check_rng(input int got, input int lo, input int hi);
    comparisons++;
    if (got < lo || got > hi) begin
      n_mismatch++;
      $display("ERROR t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
    end
  endtask
  // One Avalon transfer, held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= wr;
    avs_read      <= ~wr;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0 && n < 20) begin
      @(posedge clk);
      n++;
    end
    if (n >= 20) n_mismatch++;
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
  endtask
  // Read and compare
  task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    check_eq(rd, exp);
  endtask
  // Cycles a link output stays high; rx picks the receive side
  task automatic width_of(input logic rx, output int n);
    int k;
    k = 0;
    n = 0;
    while ((rx ? serial_side_rx_out : optical_tx_out) !== 1'b1 && k < 4000) begin
      @(posedge clk);
      k++;
    end
    while ((rx ? serial_side_rx_out : optical_tx_out) === 1'b1 && n < 5000) begin
      @(posedge clk);
      n++;
    end
  endtask
  // Control character at 9600: line high is a zero, LSB first
  task automatic send_word(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      serial_side_tx_in <= ~f[i];
      repeat (2604) @(posedge clk);
    end
  endtask
  // Verdict and end of run
  task automatic report_and_stop;
    $display("Mismatches %0d of %0d comparisons", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Hang guard
  initial begin
    repeat (60000) @(posedge clk);
    n_mismatch++;
    report_and_stop;
  end

  // Main sequence
  initial begin
    n_mismatch = 0;
    comparisons = 0;
    reset = 1'b1;
    {avs_read, avs_write, avs_address, avs_writedata, fire} = '0;
    {ir_reset_in, program_or_data_select, serial_side_tx_in} = '0;
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    rd_chk(4'h0, 32'h6);
    rd_chk(4'h4, 32'h1006);
    rd_chk(4'h8, 32'h0);
    // Fixed pulse, repeated one bit period later while held
    serial_side_tx_in <= 1'b1;
    width_of(1'b0, w);
    check_rng(w, 33, 44);
    width_of(1'b0, w);
    check_rng(w, 33, 44);
    serial_side_tx_in <= 1'b0;
    // 57600 with 3/16 width and both user bits
    bus(1'b1, 4'h0, 32'h7b);
    rd_chk(4'h4, 32'h107b);
    check_eq({30'h0, user_out_front_n, user_out_back_n}, 32'h0);
    @(posedge clk);
    serial_side_tx_in <= 1'b1;
    // Twelve ticks, first one may land right after the load
    width_of(1'b0, w);
    check_rng(w, 74, 86);
    serial_side_tx_in <= 1'b0;
    fire <= 1'b1;
    width_of(1'b1, w);
    check_rng(w, 426, 442);
    fire <= 1'b0;
    // Every rate index, then one out of range
    for (int i = 0; i < 13; i++) begin
      bus(1'b1, 4'h0, 32'(i));
      rd_chk(4'h4, 32'h1000 | 32'(i));
    end
    bus(1'b1, 4'h0, 32'hd);
    rd_chk(4'h0, 32'hc);
    // Reset pin held beyond 1 us, as a modem-control line would
    ir_reset_in <= 1'b1;
    repeat (30) @(posedge clk);
    check_eq({30'h0, transceiver_shutdown_out, osc_enable_out}, 32'h0);
    rd_chk(4'h4, 32'h206);
    ir_reset_in <= 1'b0;
    rd_chk(4'h0, 32'h6);
    // Control word over the serial line
    program_or_data_select <= 1'b1;
    send_word(8'h2b);
    rd_chk(4'h0, 32'h2b);
    rd_chk(4'h4, 32'h1106);
    program_or_data_select <= 1'b0;
    repeat (2) @(posedge clk);
    rd_chk(4'h4, 32'h102b);
    check_eq({31'h0, user_out_front_n}, 32'h0);
    report_and_stop;
  end
endmodule // tb
